// file: design/irq_regs_pkg.sv
// constants, offsets and field layout of the interrupt enable and flag registers
// Summary of operation
// - bit 7 of main enable gates all service
// - main enable: timer2, uart, timer1, pins, timer0
// - second enable: reload, compare 3..0, spi, i2c
// - third enable: comparator bit 2, adc bit 1
// - pwm register: enable bit 7, flag bit 3
// - timer2 flags: reload, overflow, compare 3..0
// - analog flags: comparator bit 1, adc bit 0
// - events set flags; service needs flag, enables
// - four levels per group, ties by order
package irq_regs_pkg;
    localparam int unsigned ADDR_W = 12;
    // printed offsets are register indexes; byte address is four times
    localparam logic [7:0] IDX_ANALOG_EN = 8'h9a;
    localparam logic [7:0] IDX_MAIN_EN   = 8'ha8;
    localparam logic [7:0] IDX_PRIO_LO   = 8'ha9;
    localparam logic [7:0] IDX_TS_EN     = 8'hb8;
    localparam logic [7:0] IDX_PRIO_HI   = 8'hb9;
    localparam logic [7:0] IDX_AN_REQ    = 8'hbf;
    localparam logic [7:0] IDX_T2_REQ    = 8'hc0;
    localparam logic [7:0] IDX_PWM_CTL   = 8'hd1;
    localparam logic [7:0] IDX_STATUS    = 8'he0;
    localparam logic [7:0] IDX_MASK      = 8'he1;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [7:0] MAIN_EN_MASK  = 8'hbf;
    localparam logic [7:0] TS_EN_MASK    = 8'hbf;
    localparam logic [7:0] AN_EN_MASK    = 8'h06;
    localparam logic [7:0] PWM_CTL_MASK  = 8'h88;
    localparam logic [7:0] T2_REQ_MASK   = 8'hfc;
    localparam logic [7:0] AN_REQ_MASK   = 8'h03;
    localparam logic [7:0] PRIO_MASK     = 8'h3f;
    localparam logic [7:0] STATUS_MASK   = 8'h07;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int T2_EN_BIT     = 5;
    localparam int UART_EN_BIT   = 4;
    localparam int T1_EN_BIT     = 3;
    localparam int EXT1_EN_BIT   = 2;
    localparam int T0_EN_BIT     = 1;
    localparam int EXT0_EN_BIT   = 0;
    localparam int T2RL_EN_BIT   = 7;
    localparam int CMP0_EN_BIT   = 2;
    localparam int SPI_EN_BIT    = 1;
    localparam int I2C_EN_BIT    = 0;
    localparam int ACMP_EN_BIT   = 2;
    localparam int ADC_EN_BIT    = 1;
    localparam int PWM_EN_BIT    = 7;
    localparam int PWM_FLAG_BIT  = 3;
    localparam int T2RL_FLAG_BIT = 7;
    localparam int T2OV_FLAG_BIT = 6;
    localparam int CMP0_FLAG_BIT = 2;
    localparam int ACMP_FLAG_BIT = 1;
    localparam int ADC_FLAG_BIT  = 0;
    localparam int ST_T2_BIT     = 0;
    localparam int ST_PWM_BIT    = 1;
    localparam int ST_AN_BIT     = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int NUM_SRC = 15;
    // source index is the default order, 0 first
    localparam logic [2:0] SRC_GROUP [0:14] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
        3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
endpackage

// file: design/irq_flag_bits.sv
// request flag bits: writable by software, hardware set wins
`timescale 1ns/10ps
`default_nettype none
module irq_flag_bits
    import irq_regs_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] set,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_val,
    output var  logic [W-1:0] q
);
    logic [W-1:0] q_d;

    always_comb begin
        q_d = wr_en ? wr_val : q;
        q_d = q_d | set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= q_d;
        end
    end

    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
        (set != '0) |=> ((q & $past(set)) == $past(set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag event lost");
endmodule
`default_nettype wire

// file: design/irq_priority_pick.sv
// picks the winning request by group level, then default order
`timescale 1ns/10ps
`default_nettype none
module irq_priority_pick
    import irq_regs_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [NUM_SRC-1:0] pend,
    input  wire logic [5:0]         prio_lo,
    input  wire logic [5:0]         prio_hi,
    output var  logic               valid_q,
    output var  logic [3:0]         id_q,
    output var  logic [1:0]         level_q
);
    logic               found;
    logic [3:0]         best_id;
    logic [1:0]         best_lvl;
    logic [1:0]         lvl;
    logic [NUM_SRC-1:0] pend_past_q;

    always_comb begin
        found    = 1'b0;
        best_id  = 4'h0;
        best_lvl = 2'h0;
        lvl      = 2'h0;
        // ascending scan with strict compare keeps the earlier source on ties
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl = {prio_hi[SRC_GROUP[i]], prio_lo[SRC_GROUP[i]]};
            if (pend[i] && (!found || lvl > best_lvl)) begin
                found    = 1'b1;
                best_id  = 4'(i);
                best_lvl = lvl;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_q     <= 1'b0;
            id_q        <= 4'h0;
            level_q     <= 2'h0;
            pend_past_q <= '0;
        end else begin
            valid_q     <= found;
            id_q        <= best_id;
            level_q     <= best_lvl;
            pend_past_q <= pend;
        end
    end

    property p_pick_pending;
        @(posedge aclk) disable iff (!aresetn)
        valid_q |-> pend_past_q[id_q];
    endproperty
    a_pick_pending: assert property (p_pick_pending) else $error("picked idle source");

    property p_pick_idle;
        @(posedge aclk) disable iff (!aresetn)
        (pend == '0) |=> !valid_q;
    endproperty
    a_pick_idle: assert property (p_pick_idle) else $error("request with none pending");
endmodule
`default_nettype wire

// file: design/interrupt_enable_flag_regs.sv
// interrupt enable and request flag registers behind an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_flag_regs
    import irq_regs_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              ext_pin_irq_a,
    input  wire logic              ext_pin_irq_b,
    input  wire logic              timer0_req,
    input  wire logic              timer1_req,
    input  wire logic              uart_req,
    input  wire logic              spi_req,
    input  wire logic              i2c_req,
    input  wire logic              timer2_reload_evt,
    input  wire logic              timer2_overflow_evt,
    input  wire logic [3:0]        compare_evt,
    input  wire logic              pwm_evt,
    input  wire logic              comparator_evt,
    input  wire logic              adc_evt,
    output var  logic              irq,
    output var  logic              svc_req,
    output var  logic [3:0]        svc_id,
    output var  logic [1:0]        svc_level
);
    logic [ADDR_W-1:0]  aw_addr_q;
    logic               aw_full_q;
    logic [7:0]         w_data_q;
    logic               w_byte_q;
    logic               w_full_q;
    logic               do_write;
    logic [7:0]         main_en_q;
    logic [7:0]         ts_en_q;
    logic [7:0]         an_en_q;
    logic               pwm_en_q;
    logic [5:0]         prio_lo_q;
    logic [5:0]         prio_hi_q;
    logic [2:0]         mask_q;
    logic [5:0]         t2_flags;
    logic [1:0]         an_flags;
    logic               pwm_flag;
    logic [2:0]         status;
    logic [5:0]         t2_set;
    logic [1:0]         an_set;
    logic [2:0]         st_set;
    logic               wr_t2;
    logic               wr_an;
    logic               wr_pwm;
    logic               wr_st;
    logic [7:0]         rd_val;
    logic               rd_hit;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] en_vec;
    logic               global_en;

    function automatic logic wr_hit(input logic [7:0] idx, input logic [ADDR_W-1:0] a);
        return a == reg_addr(idx);
    endfunction

    function automatic logic wr_known(input logic [ADDR_W-1:0] a);
        return wr_hit(IDX_ANALOG_EN, a) || wr_hit(IDX_MAIN_EN, a) || wr_hit(IDX_PRIO_LO, a)
            || wr_hit(IDX_TS_EN, a) || wr_hit(IDX_PRIO_HI, a) || wr_hit(IDX_AN_REQ, a)
            || wr_hit(IDX_T2_REQ, a) || wr_hit(IDX_PWM_CTL, a) || wr_hit(IDX_STATUS, a)
            || wr_hit(IDX_MASK, a);
    endfunction

    // write channel
    // both halves are held so the master may offer them in either order
    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            aw_addr_q     <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_full_q     <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q     <= 1'b0;
            w_data_q     <= 8'h00;
            w_byte_q     <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q     <= 1'b1;
            w_data_q     <= s_axi_wdata[7:0];
            w_byte_q     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_full_q     <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // enable and priority registers
    // registers are one byte wide, so only lane 0 is honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_en_q <= REG_RESET;
        end else if (do_write && w_byte_q && wr_hit(IDX_MAIN_EN, aw_addr_q)) begin
            main_en_q <= w_data_q & MAIN_EN_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ts_en_q <= REG_RESET;
        end else if (do_write && w_byte_q && wr_hit(IDX_TS_EN, aw_addr_q)) begin
            ts_en_q <= w_data_q & TS_EN_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            an_en_q <= REG_RESET;
        end else if (do_write && w_byte_q && wr_hit(IDX_ANALOG_EN, aw_addr_q)) begin
            an_en_q <= w_data_q & AN_EN_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_en_q <= 1'b0;
        end else if (do_write && w_byte_q && wr_hit(IDX_PWM_CTL, aw_addr_q)) begin
            pwm_en_q <= w_data_q[PWM_EN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_lo_q <= 6'h00;
            prio_hi_q <= 6'h00;
            mask_q    <= 3'h0;
        end else if (do_write && w_byte_q) begin
            if (wr_hit(IDX_PRIO_LO, aw_addr_q)) begin
                prio_lo_q <= w_data_q[5:0];
            end
            if (wr_hit(IDX_PRIO_HI, aw_addr_q)) begin
                prio_hi_q <= w_data_q[5:0];
            end
            if (wr_hit(IDX_MASK, aw_addr_q)) begin
                mask_q <= w_data_q[2:0];
            end
        end
    end

    // request flags
    assign t2_set = {timer2_reload_evt, timer2_overflow_evt, compare_evt};
    assign an_set = {comparator_evt, adc_evt};
    assign st_set = {|an_set, pwm_evt, |t2_set};
    assign wr_t2  = do_write && w_byte_q && wr_hit(IDX_T2_REQ, aw_addr_q);
    assign wr_an  = do_write && w_byte_q && wr_hit(IDX_AN_REQ, aw_addr_q);
    assign wr_pwm = do_write && w_byte_q && wr_hit(IDX_PWM_CTL, aw_addr_q);
    assign wr_st  = do_write && w_byte_q && wr_hit(IDX_STATUS, aw_addr_q);

    irq_flag_bits #(.W(6)) u_t2_flags (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (t2_set),
        .wr_en   (wr_t2),
        .wr_val  (w_data_q[7:2]),
        .q       (t2_flags)
    );

    irq_flag_bits #(.W(2)) u_an_flags (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (an_set),
        .wr_en   (wr_an),
        .wr_val  (w_data_q[1:0]),
        .q       (an_flags)
    );

    irq_flag_bits #(.W(1)) u_pwm_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (pwm_evt),
        .wr_en   (wr_pwm),
        .wr_val  (w_data_q[PWM_FLAG_BIT]),
        .q       (pwm_flag)
    );

    // status bits clear by writing one; a fresh event still wins
    irq_flag_bits #(.W(3)) u_status (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (st_set),
        .wr_en   (wr_st),
        .wr_val  (status & ~w_data_q[2:0]),
        .q       (status)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask_q);
        end
    end

    // service request
    assign global_en = main_en_q[GLOBAL_EN_BIT];

    always_comb begin
        raw    = '0;
        en_vec = '0;
        raw[0]  = ext_pin_irq_a;
        en_vec[0]  = main_en_q[EXT0_EN_BIT];
        raw[1]  = pwm_flag;
        en_vec[1]  = pwm_en_q;
        raw[2]  = i2c_req;
        en_vec[2]  = ts_en_q[I2C_EN_BIT];
        raw[3]  = timer0_req;
        en_vec[3]  = main_en_q[T0_EN_BIT];
        raw[4]  = an_flags[ADC_FLAG_BIT];
        en_vec[4]  = an_en_q[ADC_EN_BIT];
        raw[5]  = spi_req;
        en_vec[5]  = ts_en_q[SPI_EN_BIT];
        raw[6]  = ext_pin_irq_b;
        en_vec[6]  = main_en_q[EXT1_EN_BIT];
        raw[7]  = an_flags[ACMP_FLAG_BIT];
        en_vec[7]  = an_en_q[ACMP_EN_BIT];
        raw[8]  = t2_flags[0];
        en_vec[8]  = ts_en_q[CMP0_EN_BIT];
        raw[9]  = timer1_req;
        en_vec[9]  = main_en_q[T1_EN_BIT];
        raw[10] = t2_flags[1];
        en_vec[10] = ts_en_q[CMP0_EN_BIT+1];
        raw[11] = uart_req;
        en_vec[11] = main_en_q[UART_EN_BIT];
        raw[12] = t2_flags[2];
        en_vec[12] = ts_en_q[CMP0_EN_BIT+2];
        // reload request also needs its own enable beside the timer2 one
        raw[13] = t2_flags[4] || (t2_flags[5] && ts_en_q[T2RL_EN_BIT]);
        en_vec[13] = main_en_q[T2_EN_BIT];
        raw[14] = t2_flags[3];
        en_vec[14] = ts_en_q[CMP0_EN_BIT+3];
        pend = global_en ? (raw & en_vec) : '0;
    end

    irq_priority_pick u_pick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pend    (pend),
        .prio_lo (prio_lo_q),
        .prio_hi (prio_hi_q),
        .valid_q (svc_req),
        .id_q    (svc_id),
        .level_q (svc_level)
    );

    // read channel
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            reg_addr(IDX_MAIN_EN):   rd_val = main_en_q;
            reg_addr(IDX_TS_EN):     rd_val = ts_en_q;
            reg_addr(IDX_ANALOG_EN): rd_val = an_en_q;
            reg_addr(IDX_PWM_CTL):   rd_val = {pwm_en_q, 3'h0, pwm_flag, 3'h0};
            reg_addr(IDX_T2_REQ):    rd_val = {t2_flags, 2'h0};
            reg_addr(IDX_AN_REQ):    rd_val = {6'h00, an_flags};
            reg_addr(IDX_PRIO_LO):   rd_val = {2'h0, prio_lo_q};
            reg_addr(IDX_PRIO_HI):   rd_val = {2'h0, prio_hi_q};
            reg_addr(IDX_STATUS):    rd_val = {5'h00, status};
            reg_addr(IDX_MASK):      rd_val = {5'h00, mask_q};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_val};
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    property p_global_off;
        @(posedge aclk) disable iff (!aresetn)
        !main_en_q[GLOBAL_EN_BIT] |=> !svc_req;
    endproperty
    a_global_off: assert property (p_global_off) else $error("service while disabled");

    property p_main_write;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && w_byte_q && wr_hit(IDX_MAIN_EN, aw_addr_q))
            |=> main_en_q == ($past(w_data_q) & MAIN_EN_MASK);
    endproperty
    a_main_write: assert property (p_main_write) else $error("main enable not stored");

    property p_ts_reserved;
        @(posedge aclk) disable iff (!aresetn)
        ts_en_q[6] == 1'b0 && main_en_q[6] == 1'b0 && an_en_q[7:3] == 5'h00;
    endproperty
    a_ts_reserved: assert property (p_ts_reserved) else $error("reserved enable bit set");

    property p_adc_enable_gate;
        @(posedge aclk) disable iff (!aresetn)
        (an_en_q[ADC_EN_BIT] == 1'b0) |-> !pend[4];
    endproperty
    a_adc_enable_gate: assert property (p_adc_enable_gate) else $error("adc without enable");

    property p_pwm_flag_set;
        @(posedge aclk) disable iff (!aresetn)
        pwm_evt |=> pwm_flag ##1 (pwm_flag || $past(wr_pwm));
    endproperty
    a_pwm_flag_set: assert property (p_pwm_flag_set) else $error("pwm flag lost");

    property p_overflow_flag;
        @(posedge aclk) disable iff (!aresetn)
        timer2_overflow_evt |=> t2_flags[T2OV_FLAG_BIT-2];
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set");

    property p_adc_flag;
        @(posedge aclk) disable iff (!aresetn)
        adc_evt && !an_en_q[ADC_EN_BIT] |=> an_flags[ADC_FLAG_BIT];
    endproperty
    a_adc_flag: assert property (p_adc_flag) else $error("adc flag gated by enable");

    property p_reset_clear;
        @(posedge aclk)
        !aresetn |=> main_en_q == 8'h00 && t2_flags == 6'h00 && !svc_req && !irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared");

    property p_read_upper_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

    property p_write_answer;
        @(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid ##0 (s_axi_awready && s_axi_wready);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");
endmodule
`default_nettype wire

// file: verif/irq_src_model.sv
// peripheral event source model: one-cycle event pulses on request
`timescale 1ns/10ps
`default_nettype none
module irq_src_model (
    input  wire logic       aclk,
    input  wire logic [8:0] fire,
    output var  logic [8:0] evt
);
    // a request held high still gives one pulse, as a real event would
    logic [8:0] fire_q = '0;
    always @(posedge aclk) fire_q <= fire;
    assign evt = fire & ~fire_q;
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the interrupt enable and flag registers
`timescale 1ns/10ps
`default_nettype none
module tb
    import irq_regs_pkg::*;
;
    logic              aclk, aresetn, awv, wv, bready, arv, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [1:0]        bresp, rresp, svc_level, rsp;
    logic              awready, wready, bvalid, arready, rvalid, irq, svc_req;
    logic [3:0]        svc_id;
    logic [8:0]        fire, evt;
    logic [6:0]        lvl;
    logic [7:0]        rd_q;
    int                err_count, cmp_count;
    logic [7:0] idx [7] = '{IDX_ANALOG_EN, IDX_MAIN_EN, IDX_TS_EN, IDX_AN_REQ, IDX_T2_REQ,
        IDX_PWM_CTL, IDX_PRIO_LO};
    logic [7:0] msk [7] = '{AN_EN_MASK, MAIN_EN_MASK, TS_EN_MASK, AN_REQ_MASK, T2_REQ_MASK,
        PWM_CTL_MASK, PRIO_MASK};

    interrupt_enable_flag_regs u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_pin_irq_a(lvl[0]),
        .ext_pin_irq_b(lvl[1]), .timer0_req(lvl[2]), .timer1_req(lvl[3]), .uart_req(lvl[4]),
        .spi_req(lvl[5]), .i2c_req(lvl[6]), .timer2_reload_evt(evt[0]),
        .timer2_overflow_evt(evt[1]), .compare_evt(evt[5:2]), .pwm_evt(evt[6]),
        .comparator_evt(evt[7]), .adc_evt(evt[8]), .irq(irq), .svc_req(svc_req),
        .svc_id(svc_id), .svc_level(svc_level)
    );
    irq_src_model u_src (.aclk(aclk), .fire(fire), .evt(evt));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // address and data offered together, each dropped once its own ready is seen
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        // idle edge so a following call never re-raises in this step
        tick(1);
    endtask

    task automatic rd(input logic [7:0] i);
        araddr <= {2'h0, i, 2'h0};
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arv && arready) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_q = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
        tick(1);
    endtask

    task automatic pulse(input logic [8:0] m);
        fire <= m;
        tick(1);
        fire <= '0;
        tick(1);
    endtask

    task automatic t_reset();
        for (int k = 0; k < 7; k++) begin
            rd(idx[k]);
            chk("reset value", REG_RESET, rd_q);
        end
    endtask

    task automatic t_rw();
        for (int k = 0; k < 7; k++) begin
            wr(idx[k], 8'hff);
            chk("bresp", {6'h0, RESP_OKAY}, {6'h0, rsp});
            rd(idx[k]);
            chk("written bits", msk[k], rd_q);
            wr(idx[k], 8'h00);
            rd(idx[k]);
            chk("cleared bits", 8'h00, rd_q);
        end
    endtask

    task automatic t_bad();
        wr(8'h10, 8'hff);
        chk("unmapped bresp", {6'h0, RESP_SLVERR}, {6'h0, rsp});
        rd(8'h10);
        chk("unmapped rresp", {6'h0, RESP_SLVERR}, {6'h0, rsp});
    endtask

    // flags set with every enable off; service needs flag, enable and global
    task automatic t_events();
        pulse(9'h1ff);
        rd(IDX_T2_REQ);
        chk("timer2 flags", 8'hfc, rd_q);
        rd(IDX_AN_REQ);
        chk("analog flags", 8'h03, rd_q);
        rd(IDX_PWM_CTL);
        chk("pwm flag", 8'h08, rd_q);
        wr(IDX_ANALOG_EN, 8'h02);
        tick(4);
        chk("svc without global", 8'h00, {7'h0, svc_req});
        wr(IDX_MAIN_EN, 8'h80);
        tick(4);
        chk("svc req", 8'h01, {7'h0, svc_req});
        chk("svc id", 8'h04, {4'h0, svc_id});
        lvl <= 7'h7f;
        wr(IDX_MAIN_EN, 8'h81);
        tick(4);
        chk("svc id pin", 8'h00, {4'h0, svc_id});
        lvl <= 7'h00;
        wr(IDX_MAIN_EN, 8'h01);
        tick(4);
        chk("svc global off", 8'h00, {7'h0, svc_req});
    endtask

    task automatic t_prio();
        wr(IDX_ANALOG_EN, 8'h06);
        wr(IDX_MAIN_EN, 8'h80);
        tick(4);
        chk("default order", 8'h04, {4'h0, svc_id});
        wr(IDX_PRIO_LO, 8'h04);
        wr(IDX_PRIO_HI, 8'h04);
        tick(4);
        chk("level 3 id", 8'h07, {4'h0, svc_id});
        chk("level 3", 8'h03, {6'h0, svc_level});
        wr(IDX_PRIO_HI, 8'h00);
        tick(4);
        chk("level 1", 8'h01, {6'h0, svc_level});
        wr(IDX_ANALOG_EN, 8'h00);
        wr(IDX_MAIN_EN, 8'ha0);
        wr(IDX_T2_REQ, 8'h80);
        tick(4);
        chk("reload gated", 8'h00, {7'h0, svc_req});
        wr(IDX_TS_EN, 8'h80);
        tick(4);
        chk("timer2 id", 8'h0d, {4'h0, svc_id});
    endtask

    task automatic t_irq();
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(IDX_MASK, 8'h02);
        tick(2);
        chk("irq unmasked", 8'h01, {7'h0, irq});
        wr(IDX_STATUS, 8'h02);
        tick(2);
        chk("irq cleared", 8'h00, {7'h0, irq});
        rd(IDX_STATUS);
        chk("status left", 8'h05, rd_q);
        pulse(9'h040);
        tick(1);
        chk("irq again", 8'h01, {7'h0, irq});
    endtask

    initial begin
        {aresetn, awv, wv, bready, arv, rready} = '0;
        {awaddr, araddr, wdata, fire, lvl} = '0;
        tick(4);
        aresetn <= 1'b1;
        tick(1);
        t_reset();
        t_rw();
        t_bad();
        t_events();
        t_prio();
        t_irq();
        finish_test();
    end

    // whole run is a few hundred cycles; far longer means a hang
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
